// file: logic/dds_core.sv
`timescale 1ns/1ps
module dds_core
   import dds_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic profile_select_bit0_i,
   input wire logic profile_select_bit1_i,
   input wire logic profile_select_bit2_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdio_i,
   input wire logic io_reset_i,
   input wire logic pll_lock_i,
   input wire logic lock_sync_i,
   output logic sdio_o,
   output logic sdio_oe_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic lock_sync_o,
   output logic lock_sync_oe_o,
   output logic sync_clk_o,
   output logic [FTW_W-1:0] ftw_o,
   output logic [POW_W-1:0] phase_o,
   output logic [31:0] second_control_register_o
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [NSYNC-1:0] in_meta;
   logic [NSYNC-1:0] in_sync;
   logic [NSYNC-1:0] in_prev;
   logic ps0, ps1, ps2, sclk, cs_n, sdio, io_rst, pll_lock, sync_pin;
   logic ps0_q, sclk_q, sync_pin_q;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         in_meta <= '0;
         in_sync <= '0;
         in_prev <= '0;
      end else begin
         in_meta <= {profile_select_bit0_i, profile_select_bit1_i, profile_select_bit2_i,
            sclk_i, cs_n_i, sdio_i, io_reset_i, pll_lock_i, lock_sync_i};
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   assign {ps0, ps1, ps2, sclk, cs_n, sdio, io_rst, pll_lock, sync_pin} = in_sync;
   assign ps0_q = in_prev[NSYNC-1];
   assign sclk_q = in_prev[NSYNC-4];
   assign sync_pin_q = in_prev[0];

   logic sclk_rise, sclk_fall, ps0_rise, sync_rise;
   assign sclk_rise = sclk && !sclk_q;
   assign sclk_fall = !sclk && sclk_q;
   assign ps0_rise = ps0 && !ps0_q;
   assign sync_rise = sync_pin && !sync_pin_q;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [31:0] first_control_register;
   logic [FTW_W-1:0] rdelta, fdelta;
   logic [RATE_W-1:0] rrate, frate;
   logic [FTW_W-1:0] prof_ftw [NPROF];
   logic [POW_W-1:0] prof_pow [NPROF];
   logic [4:0] addr;
   logic wr_stb;
   logic [63:0] wr_data;
   logic [63:0] rd_data;
   logic [2:0] prof_idx;
   logic prof_hit;

   assign prof_idx = 3'(addr - ADDR_PROF0);
   assign prof_hit = addr >= ADDR_PROF0 && addr <= ADDR_PROF_LAST;

   // lock error is a live status bit, never stored
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         first_control_register <= CFR_RESET;
      end else if (wr_stb && addr == ADDR_FIRST_CONTROL_REGISTER) begin
         first_control_register <= wr_data[31:0] & ~(32'h1 << BIT_LOCK_ERR);
      end else if (first_control_register[BIT_SW_SYNC]) begin
         first_control_register[BIT_SW_SYNC] <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         second_control_register_o <= CFR_RESET;
      end else if (wr_stb && addr == ADDR_SECOND_CONTROL_REGISTER) begin
         second_control_register_o <= wr_data[31:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         rdelta <= '0;
         fdelta <= '0;
         rrate <= '0;
         frate <= '0;
      end else if (wr_stb) begin
         if (addr == ADDR_RDELTA) rdelta <= wr_data[FTW_W-1:0];
         if (addr == ADDR_FDELTA) fdelta <= wr_data[FTW_W-1:0];
         if (addr == ADDR_RRATE) rrate <= wr_data[RATE_W-1:0];
         if (addr == ADDR_FRATE) frate <= wr_data[RATE_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NPROF; i++) begin
            prof_ftw[i] <= '0;
            prof_pow[i] <= '0;
         end
      end else if (wr_stb && prof_hit) begin
         prof_ftw[prof_idx] <= wr_data[FTW_W-1:0];
         prof_pow[prof_idx] <= wr_data[POW_POS +: POW_W];
      end
   end

   always_comb begin
      rd_data = 64'h0;
      case (addr)
         ADDR_FIRST_CONTROL_REGISTER: begin
            rd_data[31:0] = first_control_register;
            rd_data[BIT_LOCK_ERR] = !pll_lock;
         end
         ADDR_SECOND_CONTROL_REGISTER: rd_data[31:0] = second_control_register_o;
         ADDR_RDELTA: rd_data[FTW_W-1:0] = rdelta;
         ADDR_FDELTA: rd_data[FTW_W-1:0] = fdelta;
         ADDR_RRATE: rd_data[RATE_W-1:0] = rrate;
         ADDR_FRATE: rd_data[RATE_W-1:0] = frate;
         default: begin
            if (prof_hit) begin
               rd_data[FTW_W-1:0] = prof_ftw[prof_idx];
               rd_data[POW_POS +: POW_W] = prof_pow[prof_idx];
            end
         end
      endcase
   end

   serial_port u_serial (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .sclk_rise_i(sclk_rise),
      .sclk_fall_i(sclk_fall),
      .cs_n_i(cs_n),
      .sdi_i(sdio),
      .io_reset_i(io_rst),
      .lsb_first_i(first_control_register[BIT_LSB_FIRST]),
      .sdio_in_only_i(first_control_register[BIT_SDIO_IN_ONLY]),
      .rd_data_i(rd_data),
      .addr_o(addr),
      .wr_stb_o(wr_stb),
      .wr_data_o(wr_data),
      .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o),
      .sdio_o(sdio_o),
      .sdio_oe_o(sdio_oe_o)
   );

   // ---------------------------------------------------------------
   // sync clock divider and alignment
   // ---------------------------------------------------------------
   logic [1:0] div;
   logic auto_sync, hw_sync, advance, sync_tick;

   assign auto_sync = first_control_register[BIT_AUTO_SYNC];
   assign hw_sync = first_control_register[BIT_HW_SYNC];
   assign advance = first_control_register[BIT_SW_SYNC] || (hw_sync && sync_rise);
   assign sync_tick = div == DIV_TICK;

   // the real divider wakes in an unknown phase; reset pins it for repeatable runs
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         div <= 2'h0;
      end else if (auto_sync && sync_rise) begin
         div <= DIV_ALIGN;
      end else begin
         div <= div + (advance ? DIV_ADV_STEP : DIV_STEP);
      end
   end

   // lock and sync share one pin; the hardware or the automatic sync mode turns it into an input, software sync does not
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         sync_clk_o <= 1'b0;
         lock_sync_o <= 1'b0;
         lock_sync_oe_o <= 1'b0;
      end else begin
         sync_clk_o <= div[1];
         lock_sync_o <= pll_lock;
         lock_sync_oe_o <= !(auto_sync || hw_sync);
      end
   end

   // ---------------------------------------------------------------
   // mode selection, sweep and phase accumulator
   // ---------------------------------------------------------------
   logic sweep_en, no_dwell;
   logic [2:0] sel;
   logic [FTW_W-1:0] sweep_ftw;
   logic [POW_W-1:0] pow_act;
   logic [FTW_W-1:0] acc;

   assign sweep_en = first_control_register[BIT_SWEEP_EN];
   assign no_dwell = first_control_register[BIT_NO_DWELL];
   assign sel = {ps2, ps1, ps0};

   freq_sweep u_sweep (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .tick_i(sync_tick),
      .sweep_en_i(sweep_en),
      .no_dwell_i(no_dwell),
      .dir_i(ps0),
      .trig_i(ps0_rise),
      .lower_i(prof_ftw[0]),
      .upper_i(prof_ftw[1]),
      .rdelta_i(rdelta),
      .fdelta_i(fdelta),
      .rrate_i(rrate),
      .frate_i(frate),
      .ftw_o(sweep_ftw)
   );

   // the phase word and, with the sweep off, the tuning word are latched from one index in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ftw_o <= '0;
         pow_act <= '0;
      end else begin
         ftw_o <= sweep_en ? sweep_ftw : prof_ftw[sel];
         pow_act <= prof_pow[sel];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         acc <= '0;
         phase_o <= '0;
      end else begin
         acc <= acc + ftw_o;
         phase_o <= acc[FTW_W-1 -: POW_W] + pow_act;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_acc_rate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      ##1 acc == $past(acc) + $past(ftw_o)) else $error("accumulator step wrong");
   chk_same_profile: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !sweep_en && !wr_stb && $stable(sel) |=> ftw_o == prof_ftw[$past(sel)]
      && pow_act == prof_pow[$past(sel)]) else $error("tuning and phase from other profiles");
   chk_div_free: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !advance && !(auto_sync && sync_rise) |=> div == 2'($past(div) + DIV_STEP))
      else $error("divider did not count by one");
   chk_sw_advance: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      first_control_register[BIT_SW_SYNC] && !(auto_sync && sync_rise) |=> div == 2'($past(div) + DIV_ADV_STEP)
      && (!first_control_register[BIT_SW_SYNC] || $past(wr_stb))) else $error("software advance failed");
   chk_hw_advance: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      hw_sync && sync_rise && !auto_sync |=> div == 2'($past(div) + DIV_ADV_STEP))
      else $error("hardware advance failed");
   chk_lock_pin: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      auto_sync |=> !lock_sync_oe_o) else $error("lock pin driven in slave mode");
   chk_auto_align: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      auto_sync && sync_rise |=> div == DIV_ALIGN ##1 sync_clk_o)
      else $error("sync clock not aligned to master");
endmodule : dds_core

// file: logic/dds_pkg.sv
package dds_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int FTW_W = 48;
   localparam int POW_W = 14;
   localparam int RATE_W = 16;
   localparam int NPROF = 8;
   localparam int NSYNC = 9;
   localparam int POW_POS = 48;
   // ---------------------------------------------------------------
   // serial register addresses
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_FIRST_CONTROL_REGISTER = 5'h00;
   localparam logic [4:0] ADDR_SECOND_CONTROL_REGISTER = 5'h01;
   localparam logic [4:0] ADDR_RDELTA = 5'h02;
   localparam logic [4:0] ADDR_FDELTA = 5'h03;
   localparam logic [4:0] ADDR_RRATE = 5'h04;
   localparam logic [4:0] ADDR_FRATE = 5'h05;
   localparam logic [4:0] ADDR_PROF0 = 5'h06;
   localparam logic [4:0] ADDR_PROF_LAST = 5'h0d;
   // ---------------------------------------------------------------
   // control bits and instruction fields
   // ---------------------------------------------------------------
   localparam int BIT_HS_SYNC = 0;
   localparam int BIT_HW_SYNC = 1;
   localparam int BIT_SW_SYNC = 2;
   localparam int BIT_AUTO_SYNC = 3;
   localparam int BIT_SDIO_IN_ONLY = 6;
   localparam int BIT_LSB_FIRST = 15;
   localparam int BIT_NO_DWELL = 16;
   localparam int BIT_SWEEP_EN = 17;
   localparam int BIT_LOCK_ERR = 24;
   localparam int INSTR_RD_BIT = 7;
   localparam logic [31:0] CFR_RESET = 32'h0000_0000;
   // ---------------------------------------------------------------
   // sync clock divider
   // ---------------------------------------------------------------
   localparam logic [1:0] DIV_STEP = 2'h1;
   localparam logic [1:0] DIV_ADV_STEP = 2'h2;
   localparam logic [1:0] DIV_TICK = 2'h3;
   localparam logic [1:0] DIV_ALIGN = 2'h2;

   typedef enum {SP_INSTR, SP_DATA} sp_state_e;

   function automatic logic [3:0] reg_bytes(input logic [4:0] addr);
      if (addr == ADDR_FIRST_CONTROL_REGISTER || addr == ADDR_SECOND_CONTROL_REGISTER) reg_bytes = 4'h4;
      else if (addr == ADDR_RDELTA || addr == ADDR_FDELTA) reg_bytes = 4'h6;
      else if (addr == ADDR_RRATE || addr == ADDR_FRATE) reg_bytes = 4'h2;
      else if (addr >= ADDR_PROF0 && addr <= ADDR_PROF_LAST) reg_bytes = 4'h8;
      else reg_bytes = 4'h1;
   endfunction : reg_bytes
endpackage : dds_pkg

// file: logic/freq_sweep.sv
`timescale 1ns/1ps
module freq_sweep
   import dds_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic tick_i,
   input wire logic sweep_en_i,
   input wire logic no_dwell_i,
   input wire logic dir_i,
   input wire logic trig_i,
   input wire logic [FTW_W-1:0] lower_i,
   input wire logic [FTW_W-1:0] upper_i,
   input wire logic [FTW_W-1:0] rdelta_i,
   input wire logic [FTW_W-1:0] fdelta_i,
   input wire logic [RATE_W-1:0] rrate_i,
   input wire logic [RATE_W-1:0] frate_i,
   output logic [FTW_W-1:0] ftw_o
);
   logic active;
   logic [RATE_W-1:0] rate_cnt;
   logic going_up;
   logic step;
   logic [FTW_W:0] up_sum;
   logic [FTW_W-1:0] up_next;
   logic [FTW_W-1:0] dn_next;

   assign going_up = no_dwell_i ? active : dir_i;
   // a zero rate word steps on every sync tick
   assign step = tick_i && rate_cnt >= (going_up ? rrate_i : frate_i);
   assign up_sum = {1'b0, ftw_o} + {1'b0, rdelta_i};
   // the carry bit keeps an overflowing step from wrapping below the limit
   assign up_next = (up_sum >= {1'b0, upper_i}) ? upper_i : up_sum[FTW_W-1:0];
   assign dn_next = (ftw_o < fdelta_i || ftw_o - fdelta_i <= lower_i) ?
      lower_i : ftw_o - fdelta_i;

   // ---------------------------------------------------------------
   // frequency accumulator
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ftw_o <= '0;
         rate_cnt <= '0;
         active <= 1'b0;
      end else if (!sweep_en_i) begin
         ftw_o <= lower_i;
         rate_cnt <= '0;
         active <= 1'b0;
      end else begin
         if (tick_i) rate_cnt <= step ? '0 : rate_cnt + 1'b1;
         if (no_dwell_i) begin
            if (!active) begin
               ftw_o <= lower_i;
               active <= trig_i;
            end else if (step) begin
               if (ftw_o == upper_i) begin
                  ftw_o <= lower_i;
                  active <= 1'b0;
               end else begin
                  ftw_o <= up_next;
               end
            end
         end else if (step) begin
            ftw_o <= dir_i ? up_next : dn_next;
         end
      end
   end

   chk_up_clamp: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      sweep_en_i && !no_dwell_i && dir_i && ftw_o == upper_i ##1 sweep_en_i && dir_i
      && $stable(upper_i) |-> ftw_o == upper_i) else $error("upward sweep left upper limit");
   chk_dn_clamp: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      sweep_en_i && !no_dwell_i && !dir_i && step |=> ftw_o >= $past(lower_i))
      else $error("downward sweep passed lower limit");
   chk_nodwell_wrap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      sweep_en_i && no_dwell_i && active && step && ftw_o == upper_i ##1 sweep_en_i
      |-> ftw_o == $past(lower_i) && !active) else $error("no-dwell sweep did not wrap");
endmodule : freq_sweep

// file: logic/serial_port.sv
`timescale 1ns/1ps
module serial_port
   import dds_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic sclk_rise_i,
   input wire logic sclk_fall_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   input wire logic io_reset_i,
   input wire logic lsb_first_i,
   input wire logic sdio_in_only_i,
   input wire logic [63:0] rd_data_i,
   output logic [4:0] addr_o,
   output logic wr_stb_o,
   output logic [63:0] wr_data_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic sdio_o,
   output logic sdio_oe_o
);
   sp_state_e state;
   logic [7:0] instr;
   logic [6:0] cnt;
   logic [63:0] shift;
   logic [63:0] next_shift;
   logic [6:0] nbits;
   logic [6:0] rd_idx;
   logic reading;

   assign nbits = {reg_bytes(instr[4:0]), 3'h0};
   assign reading = instr[INSTR_RD_BIT];
   assign addr_o = instr[4:0];
   assign next_shift = lsb_first_i ? {sdi_i, shift[63:1]} : {shift[62:0], sdi_i};
   assign rd_idx = lsb_first_i ? cnt : 7'(nbits - 7'h1 - cnt);

   // ---------------------------------------------------------------
   // instruction and data phases
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i || io_reset_i) begin
         state <= SP_INSTR;
         cnt <= 7'h0;
         instr <= 8'h00;
         shift <= 64'h0;
         wr_stb_o <= 1'b0;
         wr_data_o <= 64'h0;
      end else begin
         wr_stb_o <= 1'b0;
         // chip select high freezes the counters, so the cycle resumes later
         if (!cs_n_i && sclk_rise_i) begin
            case (state)
               SP_INSTR: begin
                  instr <= lsb_first_i ? {sdi_i, instr[7:1]} : {instr[6:0], sdi_i};
                  if (cnt == 7'h7) begin
                     state <= SP_DATA;
                     cnt <= 7'h0;
                  end else begin
                     cnt <= cnt + 7'h1;
                  end
               end
               SP_DATA: begin
                  shift <= next_shift;
                  if (cnt == 7'(nbits - 7'h1)) begin
                     state <= SP_INSTR;
                     cnt <= 7'h0;
                     wr_stb_o <= !reading;
                     wr_data_o <= lsb_first_i ? next_shift >> (7'h40 - nbits) : next_shift;
                  end else begin
                     cnt <= cnt + 7'h1;
                  end
               end
               default: state <= SP_INSTR;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // read data out on falling edges
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i || io_reset_i) begin
         sdo_o <= 1'b0;
         sdio_o <= 1'b0;
         sdo_oe_o <= 1'b0;
         sdio_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= !cs_n_i && state == SP_DATA && reading && sdio_in_only_i;
         sdio_oe_o <= !cs_n_i && state == SP_DATA && reading && !sdio_in_only_i;
         if (!cs_n_i && sclk_fall_i && state == SP_DATA) begin
            sdo_o <= rd_data_i[rd_idx[5:0]];
            sdio_o <= rd_data_i[rd_idx[5:0]];
         end
      end
   end

   chk_cs_tristate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cs_n_i |=> !sdo_oe_o && !sdio_oe_o) else $error("serial out driven while deselected");
   chk_io_reset_abort: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      io_reset_i |=> state == SP_INSTR && cnt == 7'h0 && !wr_stb_o)
      else $error("io reset did not abort the cycle");
endmodule : serial_port

// file: tb/ctrl_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// serial controller model
// ---------------------------------------------------------------
module ctrl_model (
   input wire logic clk_sys_i,
   input wire logic sdio_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdio_o,
   output logic io_reset_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdio_o = 1'b0;
      io_reset_o = 1'b0;
   end

   // six clocks a half period keeps the port's sync chain well inside its limit
   task automatic half();
      repeat (6) @(negedge clk_sys_i);
   endtask : half

   // nbits below the register width leaves the cycle unfinished on purpose
   task automatic xfer(input logic rd, input logic [4:0] addr, input int nbits,
                       input logic [63:0] wd, input logic lsb, output logic [63:0] rdat);
      logic [7:0] ins;
      int j;
      ins = {rd, 2'h0, addr};
      rdat = '0;
      @(negedge clk_sys_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < 8 + nbits; i++) begin
         j = i - 8;
         if (i < 8) sdio_o = lsb ? ins[i] : ins[7-i];
         else if (rd) sdio_o = ~sdio_o;
         else sdio_o = lsb ? wd[j] : wd[nbits-1-j];
         half();
         sclk_o = 1'b1;
         if (rd && i >= 8) rdat[lsb ? j : nbits-1-j] = sdio_i;
         half();
         sclk_o = 1'b0;
      end
      half();
      cs_n_o = 1'b1;
      sdio_o = ~sdio_o;
   endtask : xfer

   task automatic pulse_io_reset();
      io_reset_o = 1'b1;
      half();
      io_reset_o = 1'b0;
      half();
   endtask : pulse_io_reset
endmodule : ctrl_model

// file: tb/dds_core_tb_top.sv
`timescale 1ns/1ps
module dds_core_tb_top;
   import dds_pkg::*;
   logic clk_sys_i, reset_n_i, ps0, ps1, ps2, sclk, cs_n, m_sdio, io_rst, sync_in;
   logic sdio_o, sdio_oe_o, sdo_o, sdo_oe_o, ls_o, ls_oe_o, sync_clk_o, lsb, lock;
   logic [FTW_W-1:0] ftw_o;
   logic [31:0] second_control_register_o;
   logic [63:0] rd;
   int err_total, tests_run, n;
   wire sdio_w = sdio_oe_o ? sdio_o : m_sdio;
   wire ls_w = ls_oe_o ? ls_o : sync_in;
   localparam logic [FTW_W-1:0] BASE = 48'h1000_0000_0000;
   dds_core i_dds_core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .profile_select_bit0_i(ps0), .profile_select_bit1_i(ps1), .profile_select_bit2_i(ps2),
      .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w), .io_reset_i(io_rst), .pll_lock_i(lock),
      .lock_sync_i(ls_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o), .lock_sync_o(ls_o), .lock_sync_oe_o(ls_oe_o),
      .sync_clk_o(sync_clk_o), .ftw_o(ftw_o), .phase_o(), .second_control_register_o(second_control_register_o));
   ctrl_model i_ctrl_model (.clk_sys_i(clk_sys_i), .sdio_i(sdio_w), .sclk_o(sclk),
      .cs_n_o(cs_n), .sdio_o(m_sdio), .io_reset_o(io_rst));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
         err_total++;
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic wr(input logic [4:0] a, input int nb, input logic [63:0] d);
      i_ctrl_model.xfer(1'b0, a, nb, d, lsb, rd);
   endtask : wr
   task automatic wait_ftw(input logic [FTW_W-1:0] v);
      n = 0;
      while (ftw_o !== v && n < 400) begin
         @(negedge clk_sys_i);
         n++;
      end
      check("sweep reach", ftw_o, v);
      if (n >= 400) stop_test();
   endtask : wait_ftw
   task automatic set_ps(input logic [2:0] p);
      @(negedge clk_sys_i);
      {ps2, ps1, ps0} = p;
      repeat (8) @(negedge clk_sys_i);
   endtask : set_ps
   task automatic pulse_sync();
      repeat (2) begin
         sync_in = 1'b1;
         repeat (6) @(negedge clk_sys_i);
         sync_in = 1'b0;
         repeat (6) @(negedge clk_sys_i);
      end
   endtask : pulse_sync
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_profiles();
      for (int p = 0; p < NPROF; p++)
         wr(ADDR_PROF0 + 5'(p), 64, {2'h0, 14'(p), BASE + 48'(p * 'h111)});
      for (int p = NPROF - 1; p >= 0; p--) begin
         set_ps(3'(p));
         check("profile ftw", ftw_o, BASE + 48'(p * 'h111));
      end
   endtask : t_profiles
   task automatic t_serial(input logic l);
      if (l) wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h8000);
      lsb = l;
      wr(ADDR_SECOND_CONTROL_REGISTER, 32, 64'ha5c3_1e0f);
      check("second_control_register write", second_control_register_o, 32'ha5c3_1e0f);
      i_ctrl_model.xfer(1'b1, ADDR_SECOND_CONTROL_REGISTER, 32, '0, lsb, rd);
      check("second_control_register read", rd, 64'ha5c3_1e0f);
      check("oe idle", sdio_oe_o, 1'b0);
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h0);
      lsb = 1'b0;
   endtask : t_serial
   task automatic t_ioreset();
      wr(ADDR_SECOND_CONTROL_REGISTER, 16, 64'hffff);
      i_ctrl_model.pulse_io_reset();
      check("abort keeps", second_control_register_o, 32'ha5c3_1e0f);
      wr(ADDR_SECOND_CONTROL_REGISTER, 32, 64'h1234_5678);
      check("after abort", second_control_register_o, 32'h1234_5678);
   endtask : t_ioreset
   task automatic t_sync();
      logic sc_q;
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h4);
      i_ctrl_model.xfer(1'b1, ADDR_FIRST_CONTROL_REGISTER, 32, '0, lsb, rd);
      check("sw sync clears", rd, 64'h0);
      n = 0;
      sc_q = sync_clk_o;
      repeat (160) begin
         @(negedge clk_sys_i);
         if (sync_clk_o && !sc_q) n++;
         sc_q = sync_clk_o;
      end
      check("sync rate", 64'(n), 64'd40);
      lock = 1'b0;
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h2);
      check("hw sync pin", ls_oe_o, 1'b0);
      pulse_sync();
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h9);
      check("auto sync pin", ls_oe_o, 1'b0);
      i_ctrl_model.xfer(1'b1, ADDR_FIRST_CONTROL_REGISTER, 32, '0, lsb, rd);
      check("lock error", rd, 64'h0100_0009);
      pulse_sync();
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h0);
      lock = 1'b1;
   endtask : t_sync
   task automatic t_sweep();
      wr(ADDR_RDELTA, 48, 64'h100);
      wr(ADDR_FDELTA, 48, 64'h80);
      wr(ADDR_RRATE, 16, 64'h0);
      wr(ADDR_FRATE, 16, 64'h1);
      set_ps(3'h0);
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h2_0000);
      wait_ftw(BASE);
      set_ps(3'h1);
      wait_ftw(BASE + 48'h111);
      repeat (40) @(negedge clk_sys_i);
      check("clamp upper", ftw_o, BASE + 48'h111);
      set_ps(3'h0);
      wait_ftw(BASE + 48'h91);
      wait_ftw(BASE);
      wr(ADDR_RRATE, 16, 64'h8);
      wr(ADDR_FIRST_CONTROL_REGISTER, 32, 64'h3_0000);
      set_ps(3'h1);
      set_ps(3'h0);
      wait_ftw(BASE + 48'h100);
      wait_ftw(BASE + 48'h111);
      wait_ftw(BASE);
   endtask : t_sweep
   initial begin
      reset_n_i = 1'b0;
      {ps2, ps1, ps0} = 3'h0;
      sync_in = 1'b0;
      lock = 1'b1;
      lsb = 1'b0;
      err_total = 0;
      tests_run = 0;
      repeat (8) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      check("second_control_register reset", second_control_register_o, 32'h0);
      t_profiles();
      t_serial(1'b0);
      t_serial(1'b1);
      t_ioreset();
      t_sync();
      t_sweep();
      stop_test();
   end
endmodule : dds_core_tb_top
